// file: logic/afp_axis_config.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - fixed-parameter writes refused while run lock bit set
// - accepted write reinitialises axis position data
// - axis in use flag, resets to one
// - unused axis: no control, monitor frozen
// - rated speed in r/min, default 3000
// - latch source: input or encoder C pulse
// - same latch source for positioning commands
// - homing decel switch: soft bit or drive
// - command code word use, also needs position mode bit, enable bit defaults on
// - deviation error above setting times 2^shift
// - simulation select, resets to normal
// - reference unit 0..3, default pulse
// - decimal digits define minimum increment
// - gear forced off for pulse unit
module afp_axis_config #(
    parameter int POS_W = 32
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic [4:0]         addr,
    input  wire logic [15:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic [15:0]             rdata,
    output logic                    irq,
    input  wire logic               di_latch_in,
    input  wire logic               enc_c_pulse_in,
    input  wire logic               drive_dec_in,
    input  wire logic               soft_dec_switch_bit,
    input  wire logic [POS_W-1:0]   deviation,
    input  wire logic [15:0]        monitor_in,
    input  wire logic [15:0]        alarm_in,
    output logic                    latch_trigger,
    output logic                    dec_switch,
    output logic                    axis_control_en,
    output logic                    monitor_update,
    output logic                    axis_reinit,
    output logic                    command_code_use,
    output logic                    simulation_mode,
    output logic                    gear_active,
    output logic [1:0]              reference_unit,
    output logic [15:0]             min_increment_digits,
    output logic [15:0]             rated_motor_speed,
    output logic                    deviation_error
);
    import afp_pkg::*;
    initial begin
        if (POS_W < 32) $error("afp_axis_config: POS_W below 32");
    end

    logic        axis_in_use_reg;
    logic [15:0] rated_motor_speed_reg;
    logic        latch_source_select_reg;
    logic [15:0] additional_function_word_reg;
    logic        simulation_select_reg;
    logic [15:0] function_select_flags_reg;
    logic [15:0] digits_reg;
    logic [15:0] run_command_settings_reg;
    logic [15:0] deviation_detect_setting_reg;
    logic [15:0] position_control_mode_word_reg;
    logic [15:0] monitor_reg;
    logic [15:0] alarm_word_reg;
    logic [15:0] operating_status_word_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;

    logic fixed_sel;
    logic fixed_wr;
    logic reject;
    logic bad_unit;
    logic dev_err_raw;
    logic dev_err_d;

    // pin synchronisers: three stages, change counted when 2 and 3 agree
    logic [2:0] di_sync_reg;
    logic [2:0] c_sync_reg;
    logic [2:0] dec_sync_reg;
    logic       di_level_reg;
    logic       c_level_reg;
    logic       dec_level_reg;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            di_sync_reg   <= 3'h0;
            c_sync_reg    <= 3'h0;
            dec_sync_reg  <= 3'h0;
            di_level_reg  <= 1'b0;
            c_level_reg   <= 1'b0;
            dec_level_reg <= 1'b0;
        end else begin
            di_sync_reg  <= {di_sync_reg[1:0], di_latch_in};
            c_sync_reg   <= {c_sync_reg[1:0], enc_c_pulse_in};
            dec_sync_reg <= {dec_sync_reg[1:0], drive_dec_in};
            if (di_sync_reg[1] == di_sync_reg[2]) begin
                di_level_reg <= di_sync_reg[2];
            end
            if (c_sync_reg[1] == c_sync_reg[2]) begin
                c_level_reg <= c_sync_reg[2];
            end
            if (dec_sync_reg[1] == dec_sync_reg[2]) begin
                dec_level_reg <= dec_sync_reg[2];
            end
        end
    end

    always_comb begin
        case (addr)
            ADDR_AXIS_IN_USE, ADDR_RATED_SPEED, ADDR_LATCH_SEL,
            ADDR_ADD_FUNC, ADDR_SIM_SEL, ADDR_FUNC_FLAGS,
            ADDR_DIGITS: fixed_sel = 1'b1;
            default:     fixed_sel = 1'b0;
        endcase
    end

    assign reject   = wr && fixed_sel &&
                      run_command_settings_reg[RUN_LOCK_BIT];
    assign fixed_wr = wr && fixed_sel && !reject;
    // out-of-range unit codes are refused, the old unit stays
    assign bad_unit = fixed_wr && (addr == ADDR_FUNC_FLAGS) &&
                      (wdata[FF_UNIT_LSB +: 4] > UNIT_MAX);

    // fixed parameters
    always_ff @(posedge clk) begin
        if (!resetn) begin
            axis_in_use_reg              <= RST_AXIS_IN_USE;
            rated_motor_speed_reg        <= RST_RATED_SPEED;
            latch_source_select_reg      <= RST_LATCH_SEL;
            additional_function_word_reg <= RST_ADD_FUNC;
            simulation_select_reg        <= RST_SIM_SEL;
            function_select_flags_reg    <= RST_FUNC_FLAGS;
            digits_reg                   <= RST_DIGITS;
        end else if (fixed_wr) begin
            case (addr)
                ADDR_AXIS_IN_USE: axis_in_use_reg <= wdata[0];
                ADDR_RATED_SPEED: rated_motor_speed_reg <= wdata;
                ADDR_LATCH_SEL:   latch_source_select_reg <= wdata[0];
                ADDR_ADD_FUNC:    additional_function_word_reg <= wdata;
                ADDR_SIM_SEL:     simulation_select_reg <= wdata[0];
                ADDR_FUNC_FLAGS: begin
                    if (!bad_unit) begin
                        function_select_flags_reg <= wdata;
                    end
                end
                ADDR_DIGITS:      digits_reg <= wdata;
                default: ;
            endcase
        end
    end

    // setting parameters, never locked
    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_command_settings_reg       <= 16'h0000;
            deviation_detect_setting_reg   <= 16'hFFFF;
            position_control_mode_word_reg <= 16'h0000;
        end else if (wr) begin
            case (addr)
                ADDR_RUN_CMD:     run_command_settings_reg <= wdata;
                ADDR_DEV_SETTING: deviation_detect_setting_reg <= wdata;
                ADDR_POS_MODE:    position_control_mode_word_reg <= wdata;
                default: ;
            endcase
        end
    end

    afp_dev_check #(
        .WIDTH     (POS_W)
    ) u_dev (
        .clk       (clk),
        .resetn    (resetn),
        .deviation (deviation),
        .setting   (deviation_detect_setting_reg),
        .shift     (additional_function_word_reg[AF_SHIFT_LSB +: 4]),
        .dev_error (dev_err_raw)
    );

    // monitor and status
    always_ff @(posedge clk) begin
        if (!resetn) begin
            monitor_reg               <= 16'h0000;
            alarm_word_reg            <= 16'h0000;
            operating_status_word_reg <= 16'h0000;
            dev_err_d                 <= 1'b0;
        end else begin
            dev_err_d <= dev_err_raw;
            if (axis_in_use_reg) begin
                monitor_reg <= monitor_in;
            end
            // errors and alarms recorded whatever the axis state
            alarm_word_reg <= alarm_in;
            operating_status_word_reg <= {12'h000, bad_unit, reject,
                                          axis_in_use_reg,
                                          dev_err_raw};
        end
    end

    assign irq_event[IRQ_REJECT_BIT]   = reject;
    assign irq_event[IRQ_REINIT_BIT]   = fixed_wr && !bad_unit;
    assign irq_event[IRQ_DEV_BIT]      = dev_err_raw && !dev_err_d;
    assign irq_event[IRQ_BAD_UNIT_BIT] = bad_unit;

    // sticky bits: a new event beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_status_reg <= '0;
            irq_mask_reg   <= '0;
        end else begin
            if (wr && addr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= wdata[IRQ_W-1:0];
            end
            if (wr && addr == ADDR_IRQ_STATUS) begin
                irq_status_reg <= (irq_status_reg & ~wdata[IRQ_W-1:0])
                                  | irq_event;
            end else begin
                irq_status_reg <= irq_status_reg | irq_event;
            end
        end
    end

    // read port: data stand in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                ADDR_AXIS_IN_USE: rdata <= {15'h0000, axis_in_use_reg};
                ADDR_RATED_SPEED: rdata <= rated_motor_speed_reg;
                ADDR_LATCH_SEL:   rdata <= {15'h0000,
                                            latch_source_select_reg};
                ADDR_ADD_FUNC:    rdata <= additional_function_word_reg;
                ADDR_SIM_SEL:     rdata <= {15'h0000, simulation_select_reg};
                ADDR_FUNC_FLAGS:  rdata <= function_select_flags_reg;
                ADDR_DIGITS:      rdata <= digits_reg;
                ADDR_RUN_CMD:     rdata <= run_command_settings_reg;
                ADDR_DEV_SETTING: rdata <= deviation_detect_setting_reg;
                ADDR_STATUS:      rdata <= operating_status_word_reg;
                ADDR_IRQ_STATUS:  rdata <= {12'h000, irq_status_reg};
                ADDR_IRQ_MASK:    rdata <= {12'h000, irq_mask_reg};
                ADDR_ALARM:       rdata <= alarm_word_reg;
                ADDR_POS_MODE:    rdata <= position_control_mode_word_reg;
                default:          rdata <= monitor_reg;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // axis outputs, all registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq                  <= 1'b0;
            latch_trigger        <= 1'b0;
            dec_switch           <= 1'b0;
            axis_control_en      <= 1'b0;
            monitor_update       <= 1'b0;
            axis_reinit          <= 1'b0;
            command_code_use     <= 1'b0;
            simulation_mode      <= 1'b0;
            gear_active          <= 1'b0;
            reference_unit       <= 2'h0;
            min_increment_digits <= 16'h0000;
            rated_motor_speed    <= 16'h0000;
            deviation_error      <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
            // one source serves latch, positioning and detection commands
            latch_trigger <= latch_source_select_reg ? c_level_reg
                                                     : di_level_reg;
            dec_switch <= additional_function_word_reg[AF_DEC_SRC_BIT]
                          ? dec_level_reg : soft_dec_switch_bit;
            axis_control_en <= axis_in_use_reg;
            monitor_update  <= axis_in_use_reg;
            // a refused unit code is no change, so no reinit
            axis_reinit     <= fixed_wr && !bad_unit;
            command_code_use <=
                additional_function_word_reg[AF_CMD_EN_BIT] &&
                position_control_mode_word_reg[PM_CMD_MODE_BIT];
            simulation_mode <= simulation_select_reg;
            gear_active <= function_select_flags_reg[FF_GEAR_BIT] &&
                (function_select_flags_reg[FF_UNIT_LSB +: 4] != 4'h0);
            reference_unit <= function_select_flags_reg[FF_UNIT_LSB +: 2];
            min_increment_digits <=
                (function_select_flags_reg[FF_UNIT_LSB +: 4] == 4'h0)
                ? 16'h0000 : digits_reg;
            rated_motor_speed <= rated_motor_speed_reg;
            deviation_error <= dev_err_raw;
        end
    end
endmodule

// file: logic/afp_pkg.sv
package afp_pkg;
    localparam logic [4:0]  ADDR_AXIS_IN_USE   = 5'h01;
    localparam logic [4:0]  ADDR_RATED_SPEED   = 5'h07;
    localparam logic [4:0]  ADDR_LATCH_SEL     = 5'h0D;
    localparam logic [4:0]  ADDR_ADD_FUNC      = 5'h0E;
    localparam logic [4:0]  ADDR_SIM_SEL       = 5'h10;
    localparam logic [4:0]  ADDR_FUNC_FLAGS    = 5'h11;
    localparam logic [4:0]  ADDR_DIGITS        = 5'h12;
    localparam logic [4:0]  ADDR_RUN_CMD       = 5'h18;
    localparam logic [4:0]  ADDR_DEV_SETTING   = 5'h19;
    localparam logic [4:0]  ADDR_STATUS        = 5'h1A;
    localparam logic [4:0]  ADDR_IRQ_STATUS    = 5'h1B;
    localparam logic [4:0]  ADDR_IRQ_MASK      = 5'h1C;
    localparam logic [4:0]  ADDR_ALARM         = 5'h1D;
    localparam logic [4:0]  ADDR_POS_MODE      = 5'h1E;

    localparam logic        RST_AXIS_IN_USE    = 1'h1;
    localparam logic [15:0] RST_RATED_SPEED    = 16'h0BB8;
    localparam logic        RST_LATCH_SEL      = 1'h0;
    localparam logic [15:0] RST_ADD_FUNC       = 16'h0080;
    localparam logic        RST_SIM_SEL        = 1'h0;
    localparam logic [15:0] RST_FUNC_FLAGS     = 16'h0000;
    localparam logic [15:0] RST_DIGITS         = 16'h0003;

    localparam int RUN_LOCK_BIT     = 0;
    localparam int AF_DEC_SRC_BIT   = 2;
    localparam int AF_CMD_EN_BIT    = 7;
    localparam int AF_SHIFT_LSB     = 12;
    localparam int PM_CMD_MODE_BIT  = 2;
    localparam int FF_UNIT_LSB      = 0;
    localparam int FF_GEAR_BIT      = 4;
    localparam logic [3:0] UNIT_MAX = 4'h3;

    localparam int IRQ_REJECT_BIT   = 0;
    localparam int IRQ_REINIT_BIT   = 1;
    localparam int IRQ_DEV_BIT      = 2;
    localparam int IRQ_BAD_UNIT_BIT = 3;
    localparam int IRQ_W            = 4;
endpackage

// file: logic/afp_dev_check.sv
`timescale 1ns/100ps
module afp_dev_check #(
    parameter int WIDTH = 32
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic [WIDTH-1:0]   deviation,
    input  wire logic [15:0]        setting,
    input  wire logic [3:0]         shift,
    output logic                    dev_error
);
    import afp_pkg::*;
    initial begin
        if (WIDTH < 32) $error("afp_dev_check: WIDTH below 32");
    end
    logic [WIDTH-1:0] abs_dev;
    logic [WIDTH-1:0] limit;
    assign abs_dev = deviation[WIDTH-1] ? WIDTH'(-deviation) : deviation;
    // setting shifted by up to 15 still fits 31 bits
    assign limit = WIDTH'({16'h0000, setting}) << shift;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dev_error <= 1'b0;
        end else begin
            dev_error <= (abs_dev > limit);
        end
    end
endmodule

// file: dv/afp_drive_model.sv
`timescale 1ns/100ps
// servo drive and field pins, registered so pins move just after an edge
module afp_drive_model (
    input  wire logic        clk,
    input  wire logic [2:0]  pin_req,
    input  wire logic [31:0] dev_req,
    input  wire logic [15:0] mon_req,
    input  wire logic [15:0] alm_req,
    output logic             di_latch_in,
    output logic             enc_c_pulse_in,
    output logic             drive_dec_in,
    output logic [31:0]      deviation,
    output logic [15:0]      monitor_in,
    output logic [15:0]      alarm_in
);
    // pins start low so the sync chain never sees unknowns
    initial begin
        {drive_dec_in, enc_c_pulse_in, di_latch_in} = 3'h0;
        deviation = 32'h0;
        monitor_in = 16'h0;
        alarm_in = 16'h0;
    end
    always @(posedge clk) begin
        {drive_dec_in, enc_c_pulse_in, di_latch_in} <= pin_req;
        deviation <= dev_req;
        monitor_in <= mon_req;
        alarm_in <= alm_req;
    end
endmodule

// file: dv/afp_axis_config_asserts.sv
`timescale 1ns/100ps
module afp_axis_config_asserts
    import afp_pkg::*;
#(
    parameter int POS_W = 32
) (
    input logic             clk,
    input logic             resetn,
    input logic [4:0]       addr,
    input logic [15:0]      wdata,
    input logic             wr,
    input logic             soft_dec_switch_bit,
    input logic [POS_W-1:0] deviation,
    input logic             dec_switch,
    input logic             axis_control_en,
    input logic             monitor_update,
    input logic             axis_reinit,
    input logic             command_code_use,
    input logic             gear_active,
    input logic [1:0]       reference_unit,
    input logic [15:0]      min_increment_digits,
    input logic [15:0]      rated_motor_speed,
    input logic             deviation_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic lock_reg;
    logic af_dec_reg;
    wire is_fixed = addr inside {ADDR_AXIS_IN_USE, ADDR_RATED_SPEED,
        ADDR_LATCH_SEL, ADDR_ADD_FUNC, ADDR_SIM_SEL, ADDR_FUNC_FLAGS,
        ADDR_DIGITS};
    wire bad_unit = addr == ADDR_FUNC_FLAGS && wdata[3:0] > UNIT_MAX;
    wire fix_wr = wr && is_fixed;
    // shadow of lock and decel source, the checker cannot see registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lock_reg <= 1'b0;
            af_dec_reg <= 1'b0;
        end else if (wr && addr == ADDR_RUN_CMD) begin
            lock_reg <= wdata[RUN_LOCK_BIT];
        end else if (wr && addr == ADDR_ADD_FUNC && !lock_reg) begin
            af_dec_reg <= wdata[AF_DEC_SRC_BIT];
        end
    end
    sequence s_fix_ok;
        fix_wr && !lock_reg && !bad_unit;
    endsequence
    sequence s_fix_lock;
        fix_wr && lock_reg;
    endsequence
    fixed_write_a: assert property (s_fix_ok |=> axis_reinit)
        else $error("accepted write gave no reinit");
    locked_write_a: assert property (s_fix_lock |=>
        !axis_reinit ##1 $stable(rated_motor_speed))
        else $error("locked write took effect");
    bad_unit_a: assert property ((wr && bad_unit && !lock_reg) |=>
        !axis_reinit ##1 $stable(reference_unit))
        else $error("bad unit code accepted");
    rated_load_a: assert property
        ((fix_wr && !lock_reg && addr == ADDR_RATED_SPEED) |=>
        ##1 rated_motor_speed == $past(wdata, 2))
        else $error("rated speed not loaded");
    reset_in_use_a: assert property ($rose(resetn) |=> axis_control_en)
        else $error("axis not in use after reset");
    ctrl_monitor_a: assert property (axis_control_en == monitor_update)
        else $error("control and monitor disagree");
    gear_pulse_a: assert property (gear_active |-> reference_unit != 2'h0)
        else $error("gear active with pulse unit");
    digits_pulse_a: assert property ((reference_unit == 2'h0) |->
        min_increment_digits == 16'h0)
        else $error("digits shown for pulse unit");
    dec_soft_a: assert property (!af_dec_reg |=>
        dec_switch == $past(soft_dec_switch_bit))
        else $error("decel switch not from soft bit");
    cmd_off_a: assert property
        ((wr && addr == ADDR_POS_MODE && !wdata[PM_CMD_MODE_BIT]) |=>
        ##1 !command_code_use)
        else $error("command code use without mode bit");
    dev_zero_a: assert property ((deviation == '0) [*3] |->
        !deviation_error)
        else $error("deviation error at zero deviation");
endmodule
bind afp_axis_config afp_axis_config_asserts #(.POS_W(POS_W)) u_chk (.*);

// file: dv/afp_axis_config_tb.sv
`timescale 1ns/100ps
module afp_axis_config_tb;
    import afp_pkg::*;
    logic        clk, resetn, wr, rd, soft_dec_switch_bit, irq;
    logic        di_latch_in, enc_c_pulse_in, drive_dec_in, latch_trigger;
    logic        dec_switch, axis_control_en, monitor_update, axis_reinit;
    logic        command_code_use, simulation_mode, gear_active;
    logic        deviation_error;
    logic [4:0]  addr;
    logic [1:0]  reference_unit;
    logic [2:0]  pin_req;
    logic [15:0] wdata, rdata, monitor_in, alarm_in, min_increment_digits;
    logic [15:0] rated_motor_speed, mon_req, alm_req, v, dg;
    logic [31:0] deviation, dev_req, thr, b;
    int          miscompares, checked, sh;
    afp_axis_config uut (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .di_latch_in(di_latch_in), .enc_c_pulse_in(enc_c_pulse_in),
        .drive_dec_in(drive_dec_in),
        .soft_dec_switch_bit(soft_dec_switch_bit), .deviation(deviation),
        .monitor_in(monitor_in), .alarm_in(alarm_in),
        .latch_trigger(latch_trigger), .dec_switch(dec_switch),
        .axis_control_en(axis_control_en), .monitor_update(monitor_update),
        .axis_reinit(axis_reinit), .command_code_use(command_code_use),
        .simulation_mode(simulation_mode), .gear_active(gear_active),
        .reference_unit(reference_unit),
        .min_increment_digits(min_increment_digits),
        .rated_motor_speed(rated_motor_speed),
        .deviation_error(deviation_error));
    afp_drive_model partner (.clk(clk), .pin_req(pin_req),
        .dev_req(dev_req), .mon_req(mon_req), .alm_req(alm_req),
        .di_latch_in(di_latch_in), .enc_c_pulse_in(enc_c_pulse_in),
        .drive_dec_in(drive_dec_in), .deviation(deviation),
        .monitor_in(monitor_in), .alarm_in(alarm_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // generous span, the sequence needs well under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
    initial begin
        {resetn, wr, rd, soft_dec_switch_bit} = 4'h0;
        {addr, wdata, pin_req, dev_req, alm_req} = '0;
        mon_req = 16'h1234;
        void'($urandom(32'h5a95));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        tick(2);
        check(axis_control_en, 1'b1);
        check(monitor_update, 1'b1);
        check(rated_motor_speed, 16'h0BB8);
        check(simulation_mode, 1'b0);
        check(reference_unit, 2'h0);
        rd_chk(ADDR_AXIS_IN_USE, 16'h0001);
        rd_chk(ADDR_ADD_FUNC, 16'h0080);
        rd_chk(ADDR_LATCH_SEL, 16'h0000);
        v = $urandom;
        wr_reg(ADDR_RATED_SPEED, v);
        #1 check(axis_reinit, 1'b1);
        tick(1);
        check(rated_motor_speed, v);
        dg = $urandom;
        wr_reg(ADDR_DIGITS, dg);
        for (int u = 0; u < 4; u++) begin
            wr_reg(ADDR_FUNC_FLAGS, 16'h0010 | u);
            tick(1);
            check(reference_unit, u);
            check(gear_active, u != 0);
            check(min_increment_digits, u != 0 ? dg : 16'h0);
        end
        wr_reg(ADDR_FUNC_FLAGS, 16'h0005);
        #1 check(axis_reinit, 1'b0);
        tick(1);
        check(reference_unit, 2'h3);
        // only the refused-write event is unmasked
        wr_reg(ADDR_IRQ_MASK, 16'h0001 << IRQ_REJECT_BIT);
        wr_reg(ADDR_IRQ_STATUS, 16'h000F);
        wr_reg(ADDR_RUN_CMD, 16'h0001);
        #1 check(irq, 1'b0);
        wr_reg(ADDR_RATED_SPEED, ~v);
        #1 check(axis_reinit, 1'b0);
        tick(2);
        check(rated_motor_speed, v);
        check(irq, 1'b1);
        rd_chk(ADDR_RATED_SPEED, v);
        wr_reg(ADDR_IRQ_STATUS, 16'h0001 << IRQ_REJECT_BIT);
        tick(2);
        check(irq, 1'b0);
        wr_reg(ADDR_RUN_CMD, 16'h0000);
        wr_reg(ADDR_SIM_SEL, 16'h0001);
        tick(1);
        check(simulation_mode, 1'b1);
        for (int s = 0; s < 2; s++) begin
            wr_reg(ADDR_LATCH_SEL, s);
            pin_req <= {1'b0, s[0], !s[0]};
            tick(8);
            check(latch_trigger, 1'b1);
            pin_req <= {1'b0, !s[0], s[0]};
            tick(8);
            check(latch_trigger, 1'b0);
        end
        for (int s = 0; s < 2; s++) begin
            b = $urandom;
            wr_reg(ADDR_ADD_FUNC, 16'h0080 | (s << AF_DEC_SRC_BIT));
            soft_dec_switch_bit <= b[0];
            pin_req <= {b[1], 2'h0};
            tick(8);
            check(dec_switch, s != 0 ? b[1] : b[0]);
        end
        wr_reg(ADDR_POS_MODE, 16'h0004);
        tick(2);
        check(command_code_use, 1'b1);
        wr_reg(ADDR_POS_MODE, 16'h0000);
        tick(2);
        check(command_code_use, 1'b0);
        wr_reg(ADDR_POS_MODE, 16'h0004);
        sh = $urandom_range(0, 15);
        thr = $urandom_range(1, 200);
        wr_reg(ADDR_DEV_SETTING, thr);
        wr_reg(ADDR_ADD_FUNC, sh << AF_SHIFT_LSB);
        tick(2);
        check(command_code_use, 1'b0);
        thr = thr << sh;
        for (int i = 0; i < 3; i++) begin
            dev_req <= i == 0 ? thr : i == 1 ? thr + 1 : -(thr + 1);
            tick(5);
            check(deviation_error, i != 0);
        end
        wr_reg(5'h1F, 16'hFFFF);
        #1 check(axis_reinit, 1'b0);
        wr_reg(ADDR_AXIS_IN_USE, 16'h0000);
        tick(2);
        check(axis_control_en, 1'b0);
        check(monitor_update, 1'b0);
        mon_req <= ~mon_req;
        alm_req <= $urandom;
        tick(4);
        rd_chk(5'h1F, 16'h1234);
        rd_chk(ADDR_ALARM, alm_req);
        // deviation still above the threshold, axis unused
        rd_chk(ADDR_STATUS, 16'h0001);
        stop_test();
    end
endmodule
